// ### design/interval_counter_pkg.sv
/*
 * Constants, field layouts and state types of the interval counter access block.
 * Assumes a host port with one address, one write strobe and one read strobe per access.
 */
// Behaviour
// - Each control byte other than a read-back acts only on the counter that its select field names, in any interleaving.
// - Each counter is accessed low byte only, high byte only, or low then high in pairs.
// - A read-back command yields count, mode, output level and null-count flag of chosen counters.
// - A read-back with its count-latch bit clear latches every chosen counter's count at once.
// - A read-back with its status-latch bit clear latches status, which the next data read returns.
// - An access field of zero copies the live count into a 16-bit hold register without disturbing it.
// - After a count latch the next data read returns the held value rather than the live count.
// - Counters 1 and 2 chain into the conversion pacer while counter 0 stays free for any use.
// - The pacer time base follows a jumper choosing a 10 MHz or a 1 MHz source.
// - Control bits split into counter select, access order, mode and binary or decimal type.
// - Status carries output level in bit 7, null count in bit 6 and the programmed bits below.
// - With the pacer disabled, pacer pulses are held off the converter until the gate input is high.
// - Counter 0 counts the external clock or, when selected, an internal 100 KHz clock.
package interval_counter_pkg;

	localparam logic [3:0] OFS_COUNTER0 = 4'hC;
	localparam logic [3:0] OFS_COUNTER1 = 4'hD;
	localparam logic [3:0] OFS_COUNTER2 = 4'hE;
	localparam logic [3:0] OFS_CONTROL  = 4'hF;

	localparam int SEL_HI = 7;
	localparam int SEL_LO = 6;
	localparam int ACC_HI = 5;
	localparam int ACC_LO = 4;
	localparam int MODE_HI = 3;
	localparam int MODE_LO = 1;
	localparam int BCD_BIT = 0;
	localparam int RB_COUNT_LATCH_N = 5;
	localparam int RB_STATUS_LATCH_N = 4;
	localparam int RB_PICK_BASE = 1;

	localparam logic [1:0] SEL_READBACK = 2'h3;
	localparam logic [1:0] ACC_LATCH    = 2'h0;
	localparam logic [1:0] ACC_LOW      = 2'h1;
	localparam logic [1:0] ACC_HIGH     = 2'h2;
	localparam logic [1:0] ACC_PAIR     = 2'h3;
	localparam logic [2:0] MODE_TERMINAL = 3'h0;

	localparam logic [15:0] COUNT_ONE = 16'h0001;
	localparam logic [7:0]  BYTE_ZERO = 8'h00;

	localparam int REF_HZ       = 10_000_000;
	localparam int SLOW_BASE_HZ = 1_000_000;
	localparam int INT_CLK0_HZ  = 100_000;
	localparam int DIV_SLOW     = REF_HZ / SLOW_BASE_HZ;
	localparam int DIV_INT0     = REF_HZ / INT_CLK0_HZ;
	localparam logic [3:0] DIV_SLOW_LAST = 4'(DIV_SLOW - 1);
	localparam logic [6:0] DIV_INT0_LAST = 7'(DIV_INT0 - 1);

	typedef struct packed {
		logic [2:0]  mode;
		logic        bcd;
		logic [1:0]  access;
		logic [15:0] count_reg;
		logic [7:0]  low_tmp;
		logic [15:0] ce;
		logic [15:0] hold;
		logic        cnt_latched;
		logic [7:0]  status;
		logic        sta_latched;
		logic        rd_msb;
		logic        wr_msb;
		logic        out;
		logic        null_cnt;
		logic        armed;
		logic        term;
	} chan_type;

endpackage

// ### design/interval_counter_access.sv
/*
 * Three 16-bit interval counters with byte-wide host access, latch and read-back commands,
 * pacer chaining of counters 1 and 2 and the clock selection of counter 0.
 * Assumes host strobes and the two loose control bits come from logic on ref_clk;
 * clock, gate and jumper pins are asynchronous and are synchronised here.
 */
module interval_counter_access
	import interval_counter_pkg::*;
(
	// Clock and reset
	input  wire logic       ref_clk,
	input  wire logic       nrst,
	// Host port
	input  wire logic [3:0] io_addr,
	input  wire logic       io_wr,
	input  wire logic       io_rd,
	input  wire logic [7:0] io_wdata,
	output logic      [7:0] io_rdata,
	// Loose control bits
	input  wire logic       pacer_disable,
	input  wire logic       first_counter_clock_internal,
	// Board pins
	input  wire logic       external_pacer_gate,
	input  wire logic       first_counter_gate,
	input  wire logic       first_counter_ext_clk,
	input  wire logic       time_base_jumper,
	// Outputs
	output logic      [2:0] counter_out,
	output logic            ad_trigger
);

	typedef struct packed {
		chan_type [2:0] ch;
		logic [7:0]     rdata;
		logic           trig;
		logic [3:0]     div_slow;
		logic [6:0]     div_int;
		logic [2:0]     clk0_s;
		logic [1:0]     pgate_s;
		logic [1:0]     first_counter_gate_s;
		logic [1:0]     jumper_s;
	} state_type;

	state_type s_reg;
	state_type s_next;
	logic [2:0] tick;
	logic       slow_tick;
	logic       int_tick;
	logic       clk0_rise;

	function automatic logic [1:0] port_index(input logic [3:0] addr);
		port_index = 2'(addr - OFS_COUNTER0);
	endfunction

	function automatic logic is_data_port(input logic [3:0] addr);
		is_data_port = (addr == OFS_COUNTER0) || (addr == OFS_COUNTER1) || (addr == OFS_COUNTER2);
	endfunction

	assign slow_tick = (s_reg.div_slow == DIV_SLOW_LAST);
	assign int_tick  = (s_reg.div_int == DIV_INT0_LAST);
	assign clk0_rise = s_reg.clk0_s[1] & ~s_reg.clk0_s[2];

	assign tick[0] = s_reg.first_counter_gate_s[1] & (first_counter_clock_internal ? int_tick : clk0_rise);
	assign tick[1] = s_reg.jumper_s[1] | slow_tick;
	assign tick[2] = s_reg.ch[1].term;

	always_comb begin
		logic [15:0] val;
		logic [1:0]  idx;
		val = '0;
		idx = port_index(io_addr);
		s_next = s_reg;
		s_next.trig = 1'b0;
		s_next.clk0_s = {s_reg.clk0_s[1:0], first_counter_ext_clk};
		s_next.pgate_s = {s_reg.pgate_s[0], external_pacer_gate};
		s_next.first_counter_gate_s = {s_reg.first_counter_gate_s[0], first_counter_gate};
		s_next.jumper_s = {s_reg.jumper_s[0], time_base_jumper};
		s_next.div_slow = slow_tick ? '0 : 4'(s_reg.div_slow + 4'h1);
		s_next.div_int = int_tick ? '0 : 7'(s_reg.div_int + 7'h01);

		for (int i = 0; i < 3; i++) begin
			s_next.ch[i].term = 1'b0;
			if (s_reg.ch[i].armed && tick[i]) begin
				if (s_reg.ch[i].null_cnt) begin
					s_next.ch[i].ce = s_reg.ch[i].count_reg;
					s_next.ch[i].null_cnt = 1'b0;
				end else if (s_reg.ch[i].ce == COUNT_ONE) begin
					s_next.ch[i].ce = s_reg.ch[i].count_reg;
					s_next.ch[i].out = 1'b0;
					s_next.ch[i].term = 1'b1;
				end else begin
					s_next.ch[i].ce = 16'(s_reg.ch[i].ce - COUNT_ONE);
					s_next.ch[i].out = 1'b1;
				end
			end
		end

		s_next.trig = s_reg.ch[2].term & (~pacer_disable | s_reg.pgate_s[1]);

		if (io_wr && is_data_port(io_addr)) begin
			case (s_reg.ch[idx].access)
				ACC_LOW: begin
					s_next.ch[idx].count_reg = {BYTE_ZERO, io_wdata};
					s_next.ch[idx].null_cnt = 1'b1;
					s_next.ch[idx].armed = 1'b1;
				end
				ACC_HIGH: begin
					s_next.ch[idx].count_reg = {io_wdata, BYTE_ZERO};
					s_next.ch[idx].null_cnt = 1'b1;
					s_next.ch[idx].armed = 1'b1;
				end
				ACC_PAIR: begin
					if (s_reg.ch[idx].wr_msb) begin
						s_next.ch[idx].count_reg = {io_wdata, s_reg.ch[idx].low_tmp};
						s_next.ch[idx].null_cnt = 1'b1;
						s_next.ch[idx].armed = 1'b1;
						s_next.ch[idx].wr_msb = 1'b0;
					end else begin
						s_next.ch[idx].low_tmp = io_wdata;
						s_next.ch[idx].wr_msb = 1'b1;
					end
				end
				default: begin
					s_next.ch[idx].wr_msb = 1'b0;
				end
			endcase
		end

		s_next.rdata = s_reg.rdata;
		if (io_rd) begin
			s_next.rdata = BYTE_ZERO;
			if (is_data_port(io_addr)) begin
				val = s_reg.ch[idx].cnt_latched ? s_reg.ch[idx].hold : s_reg.ch[idx].ce;
				if (s_reg.ch[idx].sta_latched) begin
					s_next.rdata = s_reg.ch[idx].status;
					s_next.ch[idx].sta_latched = 1'b0;
				end else begin
					case (s_reg.ch[idx].access)
						ACC_LOW: begin
							s_next.rdata = val[7:0];
							s_next.ch[idx].cnt_latched = 1'b0;
						end
						ACC_HIGH: begin
							s_next.rdata = val[15:8];
							s_next.ch[idx].cnt_latched = 1'b0;
						end
						ACC_PAIR: begin
							s_next.rdata = s_reg.ch[idx].rd_msb ? val[15:8] : val[7:0];
							s_next.ch[idx].rd_msb = ~s_reg.ch[idx].rd_msb;
							if (s_reg.ch[idx].rd_msb) begin
								s_next.ch[idx].cnt_latched = 1'b0;
							end
						end
						default: begin
							s_next.rdata = val[7:0];
						end
					endcase
				end
			end
		end

		if (io_wr && io_addr == OFS_CONTROL) begin
			for (int i = 0; i < 3; i++) begin
				if (io_wdata[SEL_HI:SEL_LO] == SEL_READBACK) begin
					if (io_wdata[RB_PICK_BASE + i]) begin
						if (!io_wdata[RB_COUNT_LATCH_N] && !s_reg.ch[i].cnt_latched) begin
							s_next.ch[i].hold = s_reg.ch[i].ce;
							s_next.ch[i].cnt_latched = 1'b1;
						end
						if (!io_wdata[RB_STATUS_LATCH_N] && !s_reg.ch[i].sta_latched) begin
							s_next.ch[i].status = {s_reg.ch[i].out, s_reg.ch[i].null_cnt,
								s_reg.ch[i].access, s_reg.ch[i].mode, s_reg.ch[i].bcd};
							s_next.ch[i].sta_latched = 1'b1;
						end
					end
				end else if (io_wdata[SEL_HI:SEL_LO] == 2'(i)) begin
					if (io_wdata[ACC_HI:ACC_LO] == ACC_LATCH) begin
						if (!s_reg.ch[i].cnt_latched) begin
							s_next.ch[i].hold = s_reg.ch[i].ce;
							s_next.ch[i].cnt_latched = 1'b1;
						end
					end else begin
						s_next.ch[i].access = io_wdata[ACC_HI:ACC_LO];
						s_next.ch[i].mode = io_wdata[MODE_HI:MODE_LO];
						s_next.ch[i].bcd = io_wdata[BCD_BIT];
						s_next.ch[i].wr_msb = 1'b0;
						s_next.ch[i].rd_msb = 1'b0;
						s_next.ch[i].null_cnt = 1'b1;
						s_next.ch[i].armed = 1'b0;
						s_next.ch[i].out = (io_wdata[MODE_HI:MODE_LO] != MODE_TERMINAL);
					end
				end
			end
		end

		if (!nrst) begin
			s_next = '0;
		end
	end

	always_ff @(posedge ref_clk) begin
		s_reg <= s_next;
	end

	assign io_rdata = s_reg.rdata;
	assign ad_trigger = s_reg.trig;
	assign counter_out = {s_reg.ch[2].out, s_reg.ch[1].out, s_reg.ch[0].out};

endmodule

// ### dv/interval_counter_props.sv
/* Port assertions of the interval counter access block.
   Bound to every instance of interval_counter_access. */
module interval_counter_props
	import interval_counter_pkg::*;
(
	// Clock and reset
	input wire logic       ref_clk,
	input wire logic       nrst,
	// Host port
	input wire logic [3:0] io_addr,
	input wire logic       io_wr,
	input wire logic       io_rd,
	input wire logic [7:0] io_rdata,
	// Pins and outputs
	input wire logic       pacer_disable,
	input wire logic       first_counter_clock_internal,
	input wire logic       external_pacer_gate,
	input wire logic       first_counter_ext_clk,
	input wire logic [2:0] counter_out,
	input wire logic       ad_trigger
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!nrst);
	chk_unmapped_rd_zero: assert property (io_rd && io_addr < OFS_COUNTER0 |=> io_rdata == BYTE_ZERO)
		else $error("unmapped read not zero");
	chk_ctrl_rd_zero: assert property (io_rd && io_addr == OFS_CONTROL |=> io_rdata == BYTE_ZERO)
		else $error("control read not zero");
	chk_idle_rdata_hold: assert property (!io_rd |=> $stable(io_rdata))
		else $error("read data moved");
	chk_trig_single: assert property (ad_trigger |=> !ad_trigger)
		else $error("trigger too wide");
	chk_trig_after_out: assert property (ad_trigger |-> !$past(counter_out[2]))
		else $error("trigger without counter 2 terminal");
	chk_trig_gated: assert property ((pacer_disable && !external_pacer_gate) [*5] |=> !ad_trigger)
		else $error("trigger passed while gated");
	chk_c0_idle_hold: assert property ((!first_counter_clock_internal && !first_counter_ext_clk && !io_wr) [*5]
		|=> $stable(counter_out[0])) else $error("counter 0 moved without clock");
	chk_c2_follows_c1: assert property ((counter_out[1] && !io_wr) [*3] |=> $stable(counter_out[2]))
		else $error("counter 2 moved without counter 1");
	cov_trigger: cover property (ad_trigger);
	cov_data_read: cover property (io_rd && io_addr == OFS_COUNTER0);
	cov_gated: cover property (pacer_disable && !external_pacer_gate);
endmodule

bind interval_counter_access interval_counter_props chk_u (.*);

// ### dv/host_model.sv
/* Host program model: byte writes and reads on the counter port.
   Assumes strobes are sampled on the rising edge of ref_clk. */
module host_model (
	// Clock
	input wire logic       ref_clk,
	// Host port
	output logic     [3:0] io_addr,
	output logic           io_wr,
	output logic           io_rd,
	output logic     [7:0] io_wdata,
	input wire logic [7:0] io_rdata
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		io_addr = 4'h0;
		io_wr = 1'b0;
		io_rd = 1'b0;
		io_wdata = 8'h00;
	end
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		#1;
		io_addr = a;
		io_wdata = d;
		io_wr = 1'b1;
		@(posedge ref_clk);
		#1;
		io_wr = 1'b0;
		io_wdata = ~d;
	endtask
	task automatic rd(input logic [3:0] a, output logic [7:0] d);
		@(posedge ref_clk);
		#1;
		io_addr = a;
		io_rd = 1'b1;
		@(posedge ref_clk);
		#1;
		io_rd = 1'b0;
		d = io_rdata;
	endtask
endmodule

// ### dv/interval_counter_access_tb.sv
/* Self-checking bench of the interval counter access block.
   Assumes the host model drives the port and the bench drives the pins. */
module interval_counter_access_tb;
	import interval_counter_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	logic        ref_clk = 1'b0;
	logic        nrst = 1'b0;
	logic [3:0]  io_addr;
	logic        io_wr;
	logic        io_rd;
	logic [7:0]  io_wdata;
	logic [7:0]  io_rdata;
	logic        pacer_disable = 1'b0;
	logic        clk_int = 1'b0;
	logic        pacer_gate = 1'b0;
	logic        ext_clk = 1'b0;
	logic        jumper = 1'b1;
	logic [2:0]  counter_out;
	logic        ad_trigger;
	int          fail_count = 0;
	int          n_checks = 0;
	int          trig_n = 0;
	logic [31:0] seed = 32'h128D6;
	logic [7:0]  b;
	logic [15:0] n;
	logic [15:0] v;
	always #50 ref_clk = ~ref_clk;
	always @(posedge ref_clk) if (ad_trigger === 1'b1) trig_n++;
	host_model host_u (.ref_clk(ref_clk), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd),
		.io_wdata(io_wdata), .io_rdata(io_rdata));
	interval_counter_access dut_u (.ref_clk(ref_clk), .nrst(nrst), .io_addr(io_addr), .io_wr(io_wr),
		.io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata), .pacer_disable(pacer_disable),
		.first_counter_clock_internal(clk_int), .external_pacer_gate(pacer_gate), .first_counter_gate(1'b1),
		.first_counter_ext_clk(ext_clk), .time_base_jumper(jumper), .counter_out(counter_out),
		.ad_trigger(ad_trigger));
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function automatic logic [15:0] status_of(input logic [7:0] ctl, input logic lvl, input logic nc);
		return {8'h00, lvl, nc, ctl[5:0]};
	endfunction
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic tick0(input int k);
		repeat (k) begin
			repeat (3) @(posedge ref_clk);
			#1 ext_clk = 1'b1;
			repeat (3) @(posedge ref_clk);
			#1 ext_clk = 1'b0;
		end
		repeat (4) @(posedge ref_clk);
	endtask
	task automatic rd16(input logic [3:0] a, output logic [15:0] d);
		host_u.rd(a, d[7:0]);
		host_u.rd(a, d[15:8]);
	endtask
	task automatic pace(input int lo, input int hi);
		repeat (40) @(posedge ref_clk);
		#1 trig_n = 0;
		repeat (400) @(posedge ref_clk);
		#1 chk(16'(trig_n >= lo && trig_n <= hi), 16'h0001);
	endtask
	task automatic end_sim();
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		#(100 * 20000);
		fail_count++;
		end_sim();
	end
	initial begin
		repeat (6) @(posedge ref_clk);
		#1 nrst = 1'b1;
		repeat (3) begin
			n = 16'(rnd()) | 16'h0100;
			host_u.wr(OFS_CONTROL, 8'h34);
			host_u.wr(OFS_COUNTER0, n[7:0]);
			host_u.wr(OFS_COUNTER0, n[15:8]);
			tick0(4);
			host_u.wr(OFS_CONTROL, 8'h00);
			tick0(2);
			host_u.wr(OFS_CONTROL, 8'hB4);
			rd16(OFS_COUNTER0, v);
			chk(v, n - 16'h0003);
			host_u.wr(OFS_CONTROL, 8'hC2);
			host_u.rd(OFS_COUNTER0, b);
			chk({8'h00, b}, status_of(8'h34, 1'b1, 1'b0));
			rd16(OFS_COUNTER0, v);
			chk(v, n - 16'h0005);
		end
		for (int i = 1; i < 3; i++) begin
			b = 8'(rnd()) | 8'h02;
			host_u.wr(OFS_CONTROL, {2'h0, 2'(i), 4'h4});
			host_u.wr(OFS_COUNTER0, b);
			tick0(1);
			host_u.wr(OFS_CONTROL, 8'h00);
			host_u.rd(OFS_COUNTER0, v[7:0]);
			chk({8'h00, v[7:0]}, {8'h00, b});
		end
		host_u.rd(4'h3, b);
		chk({8'h00, b}, 16'h0000);
		$display("test done: access orders");
		clk_int = 1'b1;
		host_u.wr(OFS_CONTROL, 8'h34);
		host_u.wr(OFS_CONTROL, 8'hE2);
		host_u.rd(OFS_COUNTER0, b);
		chk({8'h00, b}, status_of(8'h34, 1'b1, 1'b1));
		host_u.wr(OFS_COUNTER0, 8'h00);
		host_u.wr(OFS_COUNTER0, 8'h10);
		repeat (300) @(posedge ref_clk);
		host_u.wr(OFS_CONTROL, 8'h00);
		rd16(OFS_COUNTER0, n);
		repeat (994) @(posedge ref_clk);
		host_u.wr(OFS_CONTROL, 8'h00);
		rd16(OFS_COUNTER0, v);
		chk(n - v, 16'h000A);
		$display("test done: internal clock");
		host_u.wr(OFS_CONTROL, 8'h74);
		host_u.wr(OFS_COUNTER1, 8'h02);
		host_u.wr(OFS_COUNTER1, 8'h00);
		host_u.wr(OFS_CONTROL, 8'hB4);
		host_u.wr(OFS_COUNTER2, 8'h02);
		host_u.wr(OFS_COUNTER2, 8'h00);
		pace(99, 101);
		jumper = 1'b0;
		pace(9, 11);
		pacer_disable = 1'b1;
		pace(0, 0);
		pacer_gate = 1'b1;
		pace(9, 11);
		$display("test done: pacer");
		end_sim();
	end
endmodule
